/* src/flash_cmd_map.svh */
// Opcodes, reset values, field positions and counts of the serial
// flash command front end. Included by the design files.
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH

`define OP_STAT1_READ       8'h05
`define OP_STAT2_READ       8'h35
`define OP_STAT3_READ       8'h15
`define OP_WRITE_LATCH_SET  8'h06
`define OP_VOLATILE_ENABLE  8'h50
`define OP_WRITE_LATCH_CLR  8'h04
`define OP_STATUS_WRITE     8'h01
`define OP_STAT2_WRITE      8'h31
`define OP_STAT3_WRITE      8'h11
`define OP_WRAP_SETUP       8'h77
`define OP_PAGE_WRITE       8'h02
`define OP_QUAD_PAGE_WRITE  8'h32
`define OP_SECTOR_CLEAR     8'h20
`define OP_BLOCK32_CLEAR    8'h52
`define OP_BLOCK64_CLEAR    8'hD8
`define OP_CHIP_CLEAR_A     8'hC7
`define OP_CHIP_CLEAR_B     8'h60
`define OP_SUSPEND          8'h75
`define OP_RESUME           8'h7A
`define OP_QUAD_ENTER       8'h38
`define OP_QUAD_EXIT        8'hFF
`define OP_SLEEP_ENTRY      8'hB9
`define OP_WAKE_AND_ID      8'hAB

`define STAT1_RST           6'h00
`define STAT2_RST           8'h00
`define STAT3_RST           8'h00
`define WRAP_RST            3'h0
// Arbitrary identifier value
`define DEVICE_ID           8'h3C

`define DATA_START_IDX      10'h004
`define WRAP_BYTE_IDX       10'h004
`define WRAP_BIT_POS        3'h6
`define PAGE_BYTES          10'h100
`define BYTE_CNT_MAX        10'h3FF
`endif

/* src/flash_cmd_pkg.sv */
// Types shared by the serial flash command front end.
// Assumes the constants of flash_cmd_map.svh.
package flash_cmd_pkg;
    typedef enum logic [2:0] {
        KIND_PROGRAM,
        KIND_SECTOR,
        KIND_BLOCK32,
        KIND_BLOCK64,
        KIND_CHIP,
        KIND_STATUS
    } op_kind_t;
endpackage

/* src/page_buf_if.sv */
// Carrier between the front end and its page buffer.
// Write side runs on the serial clock, read side is asynchronous.
`timescale 1ns/100ps
`default_nettype none
interface page_buf_if;
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    modport user  (output wr_en, wr_addr, wr_data, rd_addr,
                   input rd_data);
    modport store (input wr_en, wr_addr, wr_data, rd_addr,
                   output rd_data);
endinterface
`default_nettype wire

/* src/level_sync.sv */
// Two flip-flop synchroniser for levels.
// Assumes each bit is an independent slow level.
`timescale 1ns/100ps
`default_nettype none
module level_sync #(
    parameter int          W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_in,
    input  wire logic         reset_in,
    input  wire logic [W-1:0] d_in,
    output var  logic [W-1:0] q_out
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            meta  <= RST_VAL;
            q_out <= RST_VAL;
        end else begin
            meta  <= d_in;
            q_out <= meta;
        end
    end
endmodule
`default_nettype wire

/* src/page_buffer.sv */
// Page buffer of 256 bytes for program data.
// Written on the serial clock; read asynchronously at any time, sampled by the core on every reference clock.
`timescale 1ns/100ps
`default_nettype none
module page_buffer (
    input  wire logic   wr_clk_in,
    page_buf_if.store   pb
);
    logic [7:0] mem [256];

    always_ff @(posedge wr_clk_in) begin
        if (pb.wr_en) begin
            mem[pb.wr_addr] <= pb.wr_data;
        end
    end

    assign pb.rd_data = mem[pb.rd_addr];
endmodule
`default_nettype wire

/* src/serial_flash_command_front_end.sv */
// Command front end of a serial NOR flash: frames, decodes, executes.
// Assumes a host that stops the serial clock while chip select is high.
`timescale 1ns/100ps
`default_nettype none
`include "flash_cmd_map.svh"
module serial_flash_command_front_end (
    input  wire logic                    ref_clk_in,
    input  wire logic                    reset_in,
    input  wire logic                    sclk_in,
    input  wire logic                    cs_n_in,
    input  wire logic [3:0]              io_in,
    output var  logic [3:0]              io_out,
    output var  logic [3:0]              io_oe_out,
    output var  logic                    op_start_out,
    output var  flash_cmd_pkg::op_kind_t op_kind_out,
    output var  logic [23:0]             op_addr_out,
    output var  logic [8:0]              prog_len_out,
    input  wire logic [7:0]              prog_rd_addr_in,
    output var  logic [7:0]              prog_rd_data_out,
    input  wire logic                    op_done_in,
    output var  logic                    suspend_out,
    output var  logic                    resume_out,
    output var  logic [2:0]              wrap_bits_out,
    output var  logic [23:0]             status_out,
    output var  logic                    four_line_command_mode_out,
    output var  logic                    deep_sleep_out,
    output var  logic                    standby_out
);
    ////////////////////////////////////////////////////////////////////
    function automatic logic is_status_read(input logic [7:0] op);
        is_status_read = (op == `OP_STAT1_READ) ||
                         (op == `OP_STAT2_READ) ||
                         (op == `OP_STAT3_READ);
    endfunction

    function automatic logic is_write_cmd(input logic [7:0] op);
        case (op)
            `OP_WRITE_LATCH_SET, `OP_VOLATILE_ENABLE,
            `OP_WRITE_LATCH_CLR, `OP_STATUS_WRITE, `OP_STAT2_WRITE,
            `OP_STAT3_WRITE, `OP_PAGE_WRITE, `OP_QUAD_PAGE_WRITE,
            `OP_SECTOR_CLEAR, `OP_BLOCK32_CLEAR, `OP_BLOCK64_CLEAR,
            `OP_CHIP_CLEAR_A, `OP_CHIP_CLEAR_B:
                is_write_cmd = 1'b1;
            default:
                is_write_cmd = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Link side, clocked by the host serial clock
    page_buf_if pb ();
    page_buffer u_page_buffer (
        .wr_clk_in (sclk_in),
        .pb        (pb)
    );

    logic        link_sleep;
    logic        link_quad;
    logic [23:0] link_status;
    logic        fresh;
    logic [7:0]  shreg;
    logic [7:0]  opcode;
    logic [7:0]  byte1;
    logic [7:0]  byte2;
    logic [7:0]  byte3;
    logic [2:0]  pos;
    logic [9:0]  nbytes;
    logic [2:0]  wrap_cap;
    logic        frame_tog;
    logic [3:0]  dout;
    logic [3:0]  doe;
    logic        busy;
    logic        wel;
    logic        sleep;
    logic        quad;
    logic [5:0]  stat1;
    logic [7:0]  stat2;
    logic [7:0]  stat3;

    level_sync #(.W(24), .RST_VAL(24'h0)) u_link_sync (
        .clk_in   (sclk_in),
        .reset_in (reset_in),
        .d_in     (status_out),
        .q_out    (link_status)
    );
    // Modes change only while deselected with the serial clock stopped;
    // a synchroniser would keep the old mode for two clocks of a frame
    assign link_sleep  = sleep;
    assign link_quad   = quad;

    // Deselect clears frame state without a clock edge
    wire frame_rst = cs_n_in | reset_in;

    always_ff @(posedge sclk_in or posedge frame_rst) begin
        if (frame_rst) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    wire [2:0] cur_pos = fresh ? 3'h0 : pos;
    wire [9:0] cur_cnt = fresh ? 10'h000 : nbytes;
    wire       have_op = cur_cnt != 10'h000;
    wire       quad_data = have_op && (opcode == `OP_QUAD_PAGE_WRITE) &&
                           (cur_cnt >= `DATA_START_IDX);
    wire       nibble = link_quad | quad_data;
    wire [2:0] step = nibble ? 3'h4 : 3'h1;
    wire [7:0] next_sh = nibble ? {shreg[3:0], io_in}
                                : {shreg[6:0], io_in[0]};
    wire [3:0] pos_sum = {1'b0, cur_pos} + {1'b0, step};
    wire       byte_done = pos_sum == 4'h8;
    wire [2:0] next_pos = pos_sum[2:0];
    wire [9:0] next_cnt = (byte_done && cur_cnt != `BYTE_CNT_MAX) ?
                          cur_cnt + 10'h001 : cur_cnt;
    wire       is_wrap = have_op && (opcode == `OP_WRAP_SETUP);
    wire       wrap_spi = is_wrap && !link_quad &&
                          (cur_cnt == `WRAP_BYTE_IDX) &&
                          (cur_pos == `WRAP_BIT_POS);
    wire       wrap_quad = is_wrap && link_quad && byte_done &&
                           (cur_cnt == `WRAP_BYTE_IDX);
    wire       is_prog = have_op && ((opcode == `OP_PAGE_WRITE) ||
                                     (opcode == `OP_QUAD_PAGE_WRITE));
    wire [9:0] data_idx = cur_cnt - `DATA_START_IDX;

    // Later bytes wrap inside the page and overwrite earlier ones
    assign pb.wr_en   = is_prog && byte_done &&
                        (cur_cnt >= `DATA_START_IDX);
    assign pb.wr_addr = byte3 + data_idx[7:0];
    assign pb.wr_data = next_sh;
    assign pb.rd_addr = prog_rd_addr_in;

    always_ff @(posedge sclk_in or posedge reset_in) begin
        if (reset_in) begin
            shreg     <= 8'h00;
            pos       <= 3'h0;
            nbytes    <= 10'h000;
            opcode    <= 8'h00;
            byte1     <= 8'h00;
            byte2     <= 8'h00;
            byte3     <= 8'h00;
            wrap_cap  <= `WRAP_RST;
            frame_tog <= 1'b0;
        end else begin
            shreg  <= next_sh;
            pos    <= next_pos;
            nbytes <= next_cnt;
            if (fresh) begin
                frame_tog <= ~frame_tog;
            end
            if (byte_done && cur_cnt == 10'h000) begin
                opcode <= next_sh;
            end
            if (byte_done && cur_cnt == 10'h001) begin
                byte1 <= next_sh;
            end
            if (byte_done && cur_cnt == 10'h002) begin
                byte2 <= next_sh;
            end
            if (byte_done && cur_cnt == 10'h003) begin
                byte3 <= next_sh;
            end
            if (wrap_spi) begin
                wrap_cap <= io_in[2:0];
            end else if (wrap_quad) begin
                wrap_cap <= next_sh[6:4];
            end
        end
    end

    // Read data, launched on the falling edge after each rising edge
    wire rd_stat = (nbytes != 10'h000) && is_status_read(opcode) &&
                   !link_sleep;
    wire rd_id = (nbytes >= `DATA_START_IDX) &&
                 (opcode == `OP_WAKE_AND_ID);
    wire rd_now = !fresh && (rd_stat || rd_id);
    wire [7:0] out_byte = (opcode == `OP_STAT2_READ) ? link_status[15:8] :
                          (opcode == `OP_STAT3_READ) ? link_status[23:16] :
                          (opcode == `OP_WAKE_AND_ID) ? `DEVICE_ID :
                          link_status[7:0];
    wire [3:0] quad_out = (pos == 3'h0) ? out_byte[7:4] : out_byte[3:0];
    wire [3:0] spi_out = {2'b00, out_byte[3'h7 - pos], 1'b0};

    always_ff @(negedge sclk_in or posedge frame_rst) begin
        if (frame_rst) begin
            dout <= 4'h0;
            doe  <= 4'h0;
        end else begin
            dout <= link_quad ? quad_out : spi_out;
            doe  <= !rd_now ? 4'h0 : (link_quad ? 4'hF : 4'h2);
        end
    end
    assign io_out    = dout;
    assign io_oe_out = doe;

    ////////////////////////////////////////////////////////////////////
    // Core side. Link registers are read only after chip select has
    // risen and stayed high two cycles, so they are quiet by then.
    logic cs_s;
    logic tog_s;
    logic cs_prev;
    logic last_tog;
    logic vol;

    level_sync #(.W(2), .RST_VAL(2'b10)) u_core_sync (
        .clk_in   (ref_clk_in),
        .reset_in (reset_in),
        .d_in     ({cs_n_in, frame_tog}),
        .q_out    ({cs_s, tog_s})
    );

    wire end_evt = cs_s && !cs_prev;
    wire exec = end_evt && (tog_s != last_tog);
    wire [7:0] op = opcode;
    wire aligned = (pos == 3'h0);
    wire stat_rd = is_status_read(op);
    wire allowed = sleep ? (op == `OP_WAKE_AND_ID) :
                   (!busy || stat_rd || op == `OP_SUSPEND);
    wire go = exec && (nbytes != 10'h000) && allowed;
    wire ok_wr = go && (aligned || !is_write_cmd(op));
    wire set_wel = ok_wr && (op == `OP_WRITE_LATCH_SET);
    wire clr_wel = ok_wr && (op == `OP_WRITE_LATCH_CLR);
    wire set_vol = ok_wr && (op == `OP_VOLATILE_ENABLE);
    wire sr_any = (op == `OP_STATUS_WRITE) || (op == `OP_STAT2_WRITE) ||
                  (op == `OP_STAT3_WRITE);
    wire sr_wr = ok_wr && sr_any && (nbytes >= 10'h002) &&
                 (wel || vol);
    wire st_prog = ok_wr && wel && (nbytes > `DATA_START_IDX) &&
                   ((op == `OP_PAGE_WRITE) ||
                    (op == `OP_QUAD_PAGE_WRITE));
    wire addr_erase = (op == `OP_SECTOR_CLEAR) ||
                      (op == `OP_BLOCK32_CLEAR) ||
                      (op == `OP_BLOCK64_CLEAR);
    wire chip_erase = (op == `OP_CHIP_CLEAR_A) || (op == `OP_CHIP_CLEAR_B);
    wire st_erase = ok_wr && wel && ((addr_erase && nbytes >= 10'h004) ||
                                     chip_erase);
    wire st_sr = sr_wr && !vol;
    wire start = st_prog || st_erase || st_sr;
    wire [9:0] data_cnt = nbytes - `DATA_START_IDX;
    wire [8:0] next_len = (data_cnt > `PAGE_BYTES) ? 9'h100 : data_cnt[8:0];
    wire flash_cmd_pkg::op_kind_t next_kind =
        st_prog ? flash_cmd_pkg::KIND_PROGRAM :
        st_sr ? flash_cmd_pkg::KIND_STATUS :
        chip_erase ? flash_cmd_pkg::KIND_CHIP :
        (op == `OP_SECTOR_CLEAR) ? flash_cmd_pkg::KIND_SECTOR :
        (op == `OP_BLOCK32_CLEAR) ? flash_cmd_pkg::KIND_BLOCK32 :
        flash_cmd_pkg::KIND_BLOCK64;
    wire wr_s2 = (op == `OP_STAT2_WRITE) ||
                 (op == `OP_STATUS_WRITE && nbytes >= 10'h003);
    wire wr_s3 = (op == `OP_STAT3_WRITE) ||
                 (op == `OP_STATUS_WRITE && nbytes >= 10'h004);
    wire [7:0] s2_src = (op == `OP_STATUS_WRITE) ? byte2 : byte1;
    wire [7:0] s3_src = (op == `OP_STATUS_WRITE) ? byte3 : byte1;

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            cs_prev  <= 1'b1;
            last_tog <= 1'b0;
            busy     <= 1'b0;
            wel      <= 1'b0;
            vol      <= 1'b0;
            sleep    <= 1'b0;
            quad     <= 1'b0;
            stat1    <= `STAT1_RST;
            stat2    <= `STAT2_RST;
            stat3    <= `STAT3_RST;
            wrap_bits_out <= `WRAP_RST;
            op_start_out  <= 1'b0;
            op_kind_out   <= flash_cmd_pkg::KIND_PROGRAM;
            op_addr_out   <= 24'h000000;
            prog_len_out  <= 9'h000;
            suspend_out   <= 1'b0;
            resume_out    <= 1'b0;
            standby_out   <= 1'b0;
            prog_rd_data_out <= 8'h00;
        end else begin
            cs_prev  <= cs_s;
            if (end_evt) begin
                last_tog <= tog_s;
            end
            // A start in the same cycle as a completion wins
            busy <= start || (busy && !op_done_in);
            if (set_wel) begin
                wel <= 1'b1;
            end else if (clr_wel || start) begin
                wel <= 1'b0;
            end
            if (set_vol) begin
                vol <= 1'b1;
            end else if (sr_wr) begin
                vol <= 1'b0;
            end
            if (ok_wr && op == `OP_SLEEP_ENTRY) begin
                sleep <= 1'b1;
            end else if (go && op == `OP_WAKE_AND_ID) begin
                sleep <= 1'b0;
            end
            if (go && op == `OP_QUAD_ENTER) begin
                quad <= 1'b1;
            end else if (go && op == `OP_QUAD_EXIT) begin
                quad <= 1'b0;
            end
            if (sr_wr && op == `OP_STATUS_WRITE) begin
                stat1 <= byte1[7:2];
            end
            if (sr_wr && wr_s2) begin
                stat2 <= s2_src;
            end
            if (sr_wr && wr_s3) begin
                stat3 <= s3_src;
            end
            if (go && op == `OP_WRAP_SETUP && nbytes > `WRAP_BYTE_IDX) begin
                wrap_bits_out <= wrap_cap;
            end
            op_start_out <= start;
            if (start) begin
                op_kind_out  <= next_kind;
                op_addr_out  <= {byte1, byte2, byte3};
                prog_len_out <= st_prog ? next_len : 9'h000;
            end
            suspend_out <= go && busy && op == `OP_SUSPEND;
            resume_out  <= go && op == `OP_RESUME;
            standby_out <= cs_s && !busy && !sleep;
            prog_rd_data_out <= pb.rd_data;
        end
    end

    assign status_out = {stat3, stat2, stat1, wel, busy};
    assign four_line_command_mode_out = quad;
    assign deep_sleep_out = sleep;

    ////////////////////////////////////////////////////////////////////
    sequence s_exec_op(logic [7:0] code);
        go && op == code && aligned;
    endsequence

    a_busy_follows_start: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        op_start_out |-> status_out[0])
        else $error("busy flag missing after start");
    a_standby_only_idle: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        standby_out |-> $past(cs_s) && !$past(busy))
        else $error("standby while selected or busy");
    a_sleep_entry_holds: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        s_exec_op(`OP_SLEEP_ENTRY) |=> deep_sleep_out [*2])
        else $error("sleep not entered");
    a_sleep_blocks_ops: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        sleep |=> !op_start_out)
        else $error("operation started while asleep");
    a_misaligned_drop: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        exec && is_write_cmd(op) && !aligned
        |=> !op_start_out && $stable(status_out[23:1]))
        else $error("misaligned write acted on");
    a_busy_blocks_ops: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        busy && !op_done_in |=> !op_start_out)
        else $error("new cycle while busy");
    a_latch_set: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        s_exec_op(`OP_WRITE_LATCH_SET) |=> status_out[1])
        else $error("write latch not set");
    a_erase_needs_latch: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        op_start_out && op_kind_out != flash_cmd_pkg::KIND_STATUS
        |-> $past(wel))
        else $error("erase or program without latch");
    a_page_len_cap: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        op_start_out |-> prog_len_out <= 9'h100)
        else $error("page length above one page");
endmodule
`default_nettype wire

/* bench/host_model.sv */
// Host model: frames commands with chip select and serial clock.
// Assumes the device answers on data line 1 in single mode.
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input  wire logic       miso_in,
    output var  logic       sclk_out,
    output var  logic       cs_n_out,
    output var  logic [3:0] io_out
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        io_out   = 4'h5;
    end
    // Serial clock stands still outside frames
    task automatic xfer(input logic [47:0] data, input int nbits,
                        output logic [7:0] rd, input int nser = 48);
        int b;
        b = 0;
        rd = 8'h00;
        cs_n_out = 1'b0;
        #23;
        for (int i = 0; i < nbits; i++) begin
            // The first nser bits go singly on line 0, the rest as nibbles
            if (b < nser) begin
                io_out = {3'h0, data[47-b]};
                b = b + 1;
            end else begin
                io_out = data[47-b -: 4];
                b = b + 4;
            end
            #40 sclk_out = 1'b1;
            rd = {rd[6:0], miso_in};
            #40 sclk_out = 1'b0;
        end
        #17 cs_n_out = 1'b1;
        // Released lines flip so a stale value cannot pass for data
        io_out = ~io_out;
        #120;
    endtask
endmodule
`default_nettype wire

/* bench/serial_flash_command_front_end_tb.sv */
// Self-checking bench of the serial flash command front end.
// Assumes host_model as the far side of the link.
`timescale 1ns/100ps
`default_nettype none
`include "flash_cmd_map.svh"
module serial_flash_command_front_end_tb;
    logic ref_clk_in, reset_in, sclk, cs_n, op_start, op_done_in;
    logic [3:0] io_h, io_d, io_oe;
    logic [23:0] op_addr, status, s;
    logic [8:0] plen;
    logic [7:0] rd_addr, rd_data, rd, ops [5];
    logic [2:0] wrap;
    logic susp, resm, quad, sleep, stby;
    flash_cmd_pkg::op_kind_t kind, kinds [5];
    logic [31:0] seed = 32'hF1E4, d;
    int n_fail = 0, tests_run = 0, n_start = 0, e_start = 0, cyc = 0;
    int n_sus = 0;
    serial_flash_command_front_end i_serial_flash_command_front_end (
        .ref_clk_in(ref_clk_in), .reset_in(reset_in), .sclk_in(sclk),
        .cs_n_in(cs_n), .io_in(io_h), .io_out(io_d), .io_oe_out(io_oe),
        .op_start_out(op_start), .op_kind_out(kind),
        .op_addr_out(op_addr), .prog_len_out(plen),
        .prog_rd_addr_in(rd_addr), .prog_rd_data_out(rd_data),
        .op_done_in(op_done_in), .suspend_out(susp), .resume_out(resm),
        .wrap_bits_out(wrap), .status_out(status),
        .four_line_command_mode_out(quad), .deep_sleep_out(sleep),
        .standby_out(stby));
    // A released output line shows the inverse of its last value
    host_model i_host_model (.miso_in(io_oe[1] ? io_d[1] : ~io_d[1]),
        .sclk_out(sclk),
        .cs_n_out(cs_n), .io_out(io_h));
    initial begin
        ref_clk_in = 1'b0;
        forever #4 ref_clk_in = ~ref_clk_in;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        if (n_fail == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] op);
        i_host_model.xfer({op, 40'h0}, 8, rd);
    endtask
    task automatic done();
        @(posedge ref_clk_in) op_done_in <= 1'b1;
        @(posedge ref_clk_in) op_done_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
    endtask
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (op_start === 1'b1) n_start <= n_start + 1;
        if ((susp | resm) === 1'b1) n_sus <= n_sus + 1;
        if (cyc == 40000) begin
            n_fail++;
            conclude();
        end
    end
    //////////////////////////////////////////////////////////////////////
    initial begin
        ops = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
        kinds = '{flash_cmd_pkg::KIND_SECTOR, flash_cmd_pkg::KIND_BLOCK32,
            flash_cmd_pkg::KIND_BLOCK64, flash_cmd_pkg::KIND_CHIP,
            flash_cmd_pkg::KIND_CHIP};
        reset_in = 1'b1;
        op_done_in = 1'b0;
        rd_addr = 8'h00;
        repeat (5) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        chk(stby, 1);
        cmd(8'h06);
        chk(status[1], 1);
        i_host_model.xfer({8'h05, 40'h0}, 16, rd);
        chk(rd, 8'h02);
        cmd(8'h04);
        chk(status[1], 0);
        s = 24'(xs());
        cmd(8'h06);
        i_host_model.xfer({8'h01, s, 16'h0}, 32, rd);
        chk(kind, flash_cmd_pkg::KIND_STATUS);
        chk(status, {s[7:0], s[15:8], s[23:18], 2'b01});
        cmd(8'h06);
        chk(status[1:0], 2'b01);
        chk(stby, 0);
        cmd(8'h75);
        chk(n_sus, 1);
        done();
        chk(status[0], 0);
        i_host_model.xfer({8'h35, 40'h0}, 16, rd);
        chk(rd, s[15:8]);
        cmd(8'h7A);
        chk(n_sus, 2);
        e_start = 1;
        for (int k = 0; k < 5; k++) begin
            s = 24'(xs());
            cmd(8'h06);
            // Three bits past the last address byte must leave the erase undone
            if (k == 0) i_host_model.xfer({ops[k], s, 16'h0}, 35, rd);
            chk(n_start, e_start);
            i_host_model.xfer({ops[k], s, 16'h0}, (k < 3) ? 32 : 8, rd);
            e_start++;
            chk(n_start, e_start);
            chk(kind, kinds[k]);
            if (k < 3) chk(op_addr, s);
            done();
        end
        i_host_model.xfer({8'h20, 40'h0}, 32, rd);
        chk(n_start, e_start);
        s = 24'(xs());
        d = xs();
        cmd(8'h06);
        i_host_model.xfer({8'h02, s, d[31:16]}, 48, rd);
        chk(kind, flash_cmd_pkg::KIND_PROGRAM);
        chk(op_addr, s);
        chk(plen, 9'h002);
        @(posedge ref_clk_in) rd_addr <= s[7:0] + 8'h01;
        repeat (3) @(posedge ref_clk_in);
        chk(rd_data, d[23:16]);
        done();
        cmd(8'h06);
        i_host_model.xfer({8'h32, s, s[23:8]}, 36, rd, 32);
        chk(n_start, e_start + 2);
        chk(plen, 9'h002);
        @(posedge ref_clk_in) rd_addr <= s[7:0];
        repeat (3) @(posedge ref_clk_in);
        chk(rd_data, s[23:16]);
        done();
        cmd(8'h38);
        chk(quad, 1);
        i_host_model.xfer({8'h77, 24'h0, s[7:0], 8'h0}, 10, rd,
            0);
        chk(wrap, s[6:4]);
        i_host_model.xfer({8'hFF, 40'h0}, 2, rd, 0);
        chk(quad, 0);
        cmd(8'hB9);
        chk(sleep, 1);
        cmd(8'h06);
        chk(status[1], 0);
        i_host_model.xfer({8'hAB, 40'h0}, 40, rd);
        chk(sleep, 0);
        chk(rd, `DEVICE_ID);
        s = status;
        cmd(8'hE5);
        chk(status, s);
        chk(n_start, e_start + 2);
        conclude();
    end
endmodule
`default_nettype wire
